// File: hw/pmwc_map.vh
// Register offsets, field positions and timing counts of the power mode and wake-up control
`ifndef PMWC_MAP_VH
`define PMWC_MAP_VH
// Register addresses (8-bit special function register space)
`define PMWC_ADDR_POWER_CONTROL  8'h87
`define PMWC_ADDR_CONFIG         8'hb5
`define PMWC_ADDR_WAKE_FLAGS     8'hb6
`define PMWC_ADDR_MODE           8'hb6
// Configuration register fields
`define PMWC_CF_SLEEP            7
`define PMWC_CF_SUSPEND          6
`define PMWC_CF_CLEAR            5
`define PMWC_CF_RESET_PIN        4
`define PMWC_CF_RTC_FAIL         3
`define PMWC_CF_RTC_ALARM        2
`define PMWC_CF_PORT_MATCH       1
`define PMWC_CF_COMPARATOR       0
// Flag register fields
`define PMWC_FL_BATTERY          2
`define PMWC_FL_PULSE            0
// Mode register fields
`define PMWC_MD_RTC_OE           7
`define PMWC_MD_WAKE_OE          6
`define PMWC_MD_MON_DIS          5
`define PMWC_MD_RESET            8'h00
// Power control register fields
`define PMWC_PC_GPF_HI           7
`define PMWC_PC_GPF_LO           3
`define PMWC_PC_CORE_POWER_SOURCE_SELECT           2
`define PMWC_PC_STOP             1
`define PMWC_PC_IDLE             0
// Flags read as zero for this many clocks after a suspend wake
`define PMWC_WAKE_BLANK_CYCLES   2
`endif

// File: hw/pmwc_edge_detect.v
// Rising and falling edge detector for synchronous event inputs
`timescale 1ns/10ps
`default_nettype none
module pmwc_edge_detect #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             core_clk_i,
  input  wire             arst_n_i,
  // Levels in, one-cycle edge pulses out
  input  wire [WIDTH-1:0] level_i,
  output wire [WIDTH-1:0] rise_o,
  output wire [WIDTH-1:0] fall_o
);
  reg [WIDTH-1:0] prev_r;

  // Previous level; resets high so a high pin at reset is no fall and no rise
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_r <= {WIDTH{1'b1}};
    end else begin
      prev_r <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_r;
  assign fall_o = ~level_i & prev_r;
endmodule
`default_nettype wire

// File: hw/pmwc_blank_timer.v
// Counter that blanks flag reads for a fixed number of cycles after a wake
`timescale 1ns/10ps
`default_nettype none
module pmwc_blank_timer #(
  parameter CYCLES = 2
) (
  // Clock and reset
  input  wire core_clk_i,
  input  wire arst_n_i,
  // Start pulse and blanking level
  input  wire start_i,
  output wire blank_o
);
  reg [3:0] cnt_r;

  // Loads on start, counts down to zero
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 4'h0;
    end else if (start_i) begin
      cnt_r <= CYCLES[3:0];
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  assign blank_o = (cnt_r != 4'h0);
endmodule
`default_nettype wire

// File: hw/pmwc_top.v
// Power mode strobes, wake-up enables and sticky wake-up flags
// Notes on behaviour
// - Writing 1 to config bit 7 enters sleep; bit is write-only.
// - Writing 1 to config bit 6 enters suspend; bit is write-only.
// - Writing 1 to config bit 5 clears all wake flags in both registers.
// - Config bit 4 reads set after reset pin falling edge, sticky until cleared.
// - Config bit 3: oscillator-fail wake enable on write, flag on read.
// - Config bit 2: alarm wake enable on write, flag on read.
// - Config bit 1: port match wake enable on write, flag on read.
// - Config bit 0: comparator rising edge wake enable on write, flag on read.
// - Any set flag refuses suspend/sleep and keeps low-power oscillator running.
// - Flags read zero for two clocks after waking from suspend.
// - Flag register bit 2: battery monitor wake enable and flag.
// - Flag register bit 0: pulse counter wake enable and flag.
// - Mode bit 7 enables buffered clock output on port pin.
// - Mode bit 6 enables wake request signal on port pin.
// - Mode bit 5 disables supply monitor; bits 4, 3 and 1 read zero.
// - Power control bits 7..3 are read/write general purpose flags.
// - Power control bit 2 selects core supply: 0 battery, 1 converter.
// - Writing 1 to power control bit 1 enters stop mode.
// - Writing 1 to power control bit 0 enters idle mode.
// - Leaving sleep drives the wake request signal low.
// - With monitor disabled any reset gives full power-on reset, re-enabling monitor.
// - Suspend gates system clock until enabled wake or reset pin fall and stops oscillators while no flag is set.
// - Flags set on their events whether enabled or not, also while awake.
`timescale 1ns/10ps
`default_nettype none
`include "pmwc_map.vh"
module pmwc_top #(
  parameter BLANK_CYCLES = `PMWC_WAKE_BLANK_CYCLES
) (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       arst_n_i,
  // Special function register port
  input  wire [7:0] sfr_addr_i,
  input  wire [7:0] sfr_wdata_i,
  input  wire       sfr_wr_i,
  input  wire       sfr_rd_i,
  output reg  [7:0] sfr_rdata_o,
  // Wake event sources (levels, synchronous)
  input  wire       reset_pin_i,
  input  wire       rtc_osc_fail_i,
  input  wire       rtc_alarm_i,
  input  wire       port_match_i,
  input  wire       comparator_i,
  input  wire       battery_monitor_i,
  input  wire       pulse_counter_i,
  // Reset source reporting
  input  wire       any_reset_req_i,
  // Mode and power outputs
  output reg        sleep_o,
  output reg        suspend_o,
  output reg        stop_o,
  output reg        idle_o,
  output reg        sys_clk_gate_o,
  output reg        lp_osc_keep_o,
  output reg        full_por_o,
  output reg        supply_monitor_disable_o,
  output reg        core_power_source_select_o,
  output reg        rtc_clock_output_enable_o,
  output reg        wake_request_n_o,
  output reg        wake_request_oe_o
);
  // Wake flags and enables
  reg  [4:0] cf_flag_r;       // reset pin, osc fail, alarm, port match, comparator
  reg  [3:0] cf_en_r;         // osc fail, alarm, port match, comparator
  reg        bat_flag_r;
  reg        pulse_flag_r;
  reg        bat_en_r;
  reg        pulse_en_r;
  reg  [2:0] mode_r;          // clock out enable, wake out enable, monitor disable
  reg  [4:0] gpf_r;
  reg        core_power_source_select_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg        wake_pulse_r;

  // Power states, one-hot
  localparam [2:0] ST_ACTIVE  = 3'h1;
  localparam [2:0] ST_SLEEP   = 3'h2;
  localparam [2:0] ST_SUSPEND = 3'h4;
  // Mode register reset image; only its top three bits are stored
  localparam [7:0] MD_RESET   = `PMWC_MD_RESET;

  wire [5:0] rise;
  wire       sleeping;
  wire       suspended;
  wire       blank;
  wire       wr_cf;
  wire       wr_fl;
  wire       wr_pc;
  wire       any_flag;
  wire       wake_evt;
  wire       rst_fall;
  wire       clear_req;
  wire       lowpwr_req;

  // Edge detection of all event sources except the reset pin
  pmwc_edge_detect #(
    .WIDTH (6)
  ) u_edges (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .level_i    ({pulse_counter_i, battery_monitor_i, rtc_osc_fail_i,
                  rtc_alarm_i, port_match_i, comparator_i}),
    .rise_o     (rise),
    .fall_o     ()
  );

  // Separate falling-edge detector for the reset pin
  // Pin idles high and the detector resets high, so release gives no false fall
  wire [0:0] rst_fall_vec;
  pmwc_edge_detect #(
    .WIDTH (1)
  ) u_rst_edge (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .level_i    (reset_pin_i),
    .rise_o     (),
    .fall_o     (rst_fall_vec)
  );
  assign rst_fall = rst_fall_vec[0];

  // Flag read blanking after a suspend wake
  pmwc_blank_timer #(
    .CYCLES (BLANK_CYCLES)
  ) u_blank (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .start_i    (suspended & wake_evt),
    .blank_o    (blank)
  );

  // Write strobe aimed at one register address
  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_hit = wr & (addr == target);
    end
  endfunction

  // Write decode; flag and mode registers share one address
  assign wr_cf = wr_hit(sfr_wr_i, sfr_addr_i, `PMWC_ADDR_CONFIG);
  assign wr_fl = wr_hit(sfr_wr_i, sfr_addr_i, `PMWC_ADDR_WAKE_FLAGS);
  assign wr_pc = wr_hit(sfr_wr_i, sfr_addr_i, `PMWC_ADDR_POWER_CONTROL);
  assign sleeping  = state_r[1];
  assign suspended = state_r[2];
  assign clear_req = wr_cf & sfr_wdata_i[`PMWC_CF_CLEAR];
  assign lowpwr_req = wr_cf & (sfr_wdata_i[`PMWC_CF_SLEEP] | sfr_wdata_i[`PMWC_CF_SUSPEND]);
  assign any_flag = (|cf_flag_r) | bat_flag_r | pulse_flag_r;

  // Enabled event or reset pin fall ends low power
  assign wake_evt = rst_fall | (|(rise[3:0] & cf_en_r)) | (rise[4] & bat_en_r)
                    | (rise[5] & pulse_en_r);

  // Wake flags: event set wins over clear
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cf_flag_r    <= 5'h00;
      bat_flag_r   <= 1'b0;
      pulse_flag_r <= 1'b0;
    end else begin
      cf_flag_r[4]   <= rst_fall | (cf_flag_r[4] & ~clear_req);
      cf_flag_r[3:0] <= rise[3:0] | (cf_flag_r[3:0] & {4{~clear_req}});
      bat_flag_r     <= rise[4] | (bat_flag_r & ~clear_req);
      pulse_flag_r   <= rise[5] | (pulse_flag_r & ~clear_req);
    end
  end

  // Enables and plain control registers
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cf_en_r    <= 4'h0;
      bat_en_r   <= 1'b0;
      pulse_en_r <= 1'b0;
      mode_r     <= MD_RESET[7:5];
      gpf_r      <= 5'h00;
      core_power_source_select_r   <= 1'b0;
    end else begin
      if (wr_cf) begin
        cf_en_r <= sfr_wdata_i[3:0];
      end
      if (wr_fl) begin
        bat_en_r   <= sfr_wdata_i[`PMWC_FL_BATTERY];
        pulse_en_r <= sfr_wdata_i[`PMWC_FL_PULSE];
        mode_r     <= sfr_wdata_i[7:5];
      end
      if (any_reset_req_i && mode_r[0]) begin
        mode_r[0] <= 1'b0;
      end
      if (wr_pc) begin
        gpf_r    <= sfr_wdata_i[`PMWC_PC_GPF_HI:`PMWC_PC_GPF_LO];
        core_power_source_select_r <= sfr_wdata_i[`PMWC_PC_CORE_POWER_SOURCE_SELECT];
      end
    end
  end

  // Next power state; a standing flag refuses entry and sleep wins over suspend
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (lowpwr_req && !any_flag) begin
          if (sfr_wdata_i[`PMWC_CF_SLEEP]) begin
            state_nxt = ST_SLEEP;
          end else begin
            state_nxt = ST_SUSPEND;
          end
        end
      end
      ST_SLEEP: begin
        // Only an enabled source or the reset pin ends sleep
        if (wake_evt) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_SUSPEND: begin
        // Clock stays gated until an enabled wake or a reset pin fall arrives
        if (wake_evt) begin
          state_nxt = ST_ACTIVE;
        end
      end
      default: begin
        state_nxt = ST_ACTIVE;
      end
    endcase
  end

  // Power state and the one-cycle marker of a wake from sleep
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r      <= ST_ACTIVE;
      wake_pulse_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      wake_pulse_r <= sleeping & wake_evt;
    end
  end

  // Registered outputs
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sleep_o                    <= 1'b0;
      suspend_o                  <= 1'b0;
      stop_o                     <= 1'b0;
      idle_o                     <= 1'b0;
      sys_clk_gate_o             <= 1'b0;
      lp_osc_keep_o              <= 1'b1;
      full_por_o                 <= 1'b0;
      supply_monitor_disable_o   <= 1'b0;
      core_power_source_select_o <= 1'b0;
      rtc_clock_output_enable_o  <= 1'b0;
      wake_request_n_o           <= 1'b1;
      wake_request_oe_o          <= 1'b0;
    end else begin
      sleep_o                    <= sleeping;
      suspend_o                  <= suspended;
      stop_o                     <= wr_pc & sfr_wdata_i[`PMWC_PC_STOP];
      idle_o                     <= wr_pc & sfr_wdata_i[`PMWC_PC_IDLE];
      sys_clk_gate_o             <= suspended;
      lp_osc_keep_o              <= any_flag | ~suspended;
      full_por_o                 <= any_reset_req_i & mode_r[0];
      supply_monitor_disable_o   <= mode_r[0];
      core_power_source_select_o <= core_power_source_select_r;
      rtc_clock_output_enable_o  <= mode_r[2];
      wake_request_oe_o          <= mode_r[1];
      // Low pulse on wake from sleep, idle high otherwise
      wake_request_n_o           <= ~(wake_pulse_r & mode_r[1]);
    end
  end

  // Read data; write-only bits and unused bits read zero
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        `PMWC_ADDR_CONFIG:        sfr_rdata_o <= blank ? 8'h00 : {3'h0, cf_flag_r};
        `PMWC_ADDR_WAKE_FLAGS:    sfr_rdata_o <= blank ? {mode_r, 5'h00} :
                                  {mode_r, 2'h0, bat_flag_r, 1'b0, pulse_flag_r};
        `PMWC_ADDR_POWER_CONTROL: sfr_rdata_o <= {gpf_r, core_power_source_select_r, 2'h0};
        default:                  sfr_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: dv/pmwc_chk.sv
// Concurrent property checker for the power mode and wake-up control ports
`timescale 1ns/10ps
`default_nettype none
module pmwc_chk (
  // Clock, reset and register port
  input wire logic       core_clk_i,
  input wire logic       arst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_wr_i,
  input wire logic       any_reset_req_i,
  // Mode and power outputs
  input wire logic       sleep_o,
  input wire logic       suspend_o,
  input wire logic       stop_o,
  input wire logic       idle_o,
  input wire logic       sys_clk_gate_o,
  input wire logic       lp_osc_keep_o,
  input wire logic       full_por_o,
  input wire logic       supply_monitor_disable_o,
  input wire logic       core_power_source_select_o,
  input wire logic       rtc_clock_output_enable_o,
  input wire logic       wake_request_n_o,
  input wire logic       wake_request_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Write decodes for the two control registers
  wire w_pc = sfr_wr_i && (sfr_addr_i == 8'h87);
  wire w_md = sfr_wr_i && (sfr_addr_i == 8'hb6);
  chk_stop_strobe: assert property (w_pc |=> stop_o == $past(sfr_wdata_i[1]))
    else $error("stop strobe wrong");
  chk_idle_strobe: assert property (w_pc |=> idle_o == $past(sfr_wdata_i[0]))
    else $error("idle strobe wrong");
  chk_power_select: assert property (w_pc |-> ##2
    core_power_source_select_o == $past(sfr_wdata_i[2], 2))
    else $error("power select wrong");
  chk_clock_out_en: assert property (w_md |-> ##2
    rtc_clock_output_enable_o == $past(sfr_wdata_i[7], 2))
    else $error("clock output enable wrong");
  chk_wake_out_en: assert property (w_md |-> ##2
    wake_request_oe_o == $past(sfr_wdata_i[6], 2))
    else $error("wake output enable wrong");
  chk_gate_follows: assert property (sys_clk_gate_o == suspend_o)
    else $error("clock gate differs from suspend");
  chk_osc_awake: assert property (!suspend_o |-> lp_osc_keep_o)
    else $error("oscillator dropped while awake");
  chk_modes_exclusive: assert property (!(sleep_o && suspend_o))
    else $error("sleep and suspend together");
  chk_por_full: assert property (any_reset_req_i && supply_monitor_disable_o |=> full_por_o)
    else $error("no full power-on reset");
  chk_monitor_back: assert property (any_reset_req_i && !sfr_wr_i |-> ##2
    !supply_monitor_disable_o)
    else $error("monitor not re-enabled");
  chk_wake_pulse: assert property ($fell(wake_request_n_o) |-> wake_request_oe_o ##1 wake_request_n_o)
    else $error("wake request pulse wrong");
  // Main scenarios reached
  cov_stop: cover property (stop_o);
  cov_suspend: cover property ($rose(suspend_o));
  cov_wake: cover property ($fell(wake_request_n_o));
endmodule
bind pmwc_top pmwc_chk pmwc_chk_inst (.core_clk_i, .arst_n_i, .sfr_addr_i, .sfr_wdata_i,
  .sfr_wr_i, .any_reset_req_i, .sleep_o, .suspend_o, .stop_o, .idle_o, .sys_clk_gate_o,
  .lp_osc_keep_o, .full_por_o, .supply_monitor_disable_o, .core_power_source_select_o,
  .rtc_clock_output_enable_o, .wake_request_n_o, .wake_request_oe_o);
`default_nettype wire

// File: dv/tb.sv
// Register-level testbench for the power mode and wake-up control
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic       wr = 1'b0, rd = 1'b0, por_req = 1'b0;
  logic [6:0] src = 7'h00; // 0 comp,1 match,2 alarm,3 fail,4 pin,5 pulse,6 battery
  wire        slp, sus, stp, idl, gate, osc, por, mdis, psel, rtc_clock_output_enable, wk_n, wkoe;
  int         fails = 0, check_count = 0, cyc = 0, n;
  pmwc_top pmwc_top_inst (.core_clk_i(clk), .arst_n_i(rst_n), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
    .reset_pin_i(~src[4]), .rtc_osc_fail_i(src[3]), .rtc_alarm_i(src[2]),
    .port_match_i(src[1]), .comparator_i(src[0]), .battery_monitor_i(src[6]),
    .pulse_counter_i(src[5]), .any_reset_req_i(por_req), .sleep_o(slp), .suspend_o(sus),
    .stop_o(stp), .idle_o(idl), .sys_clk_gate_o(gate), .lp_osc_keep_o(osc),
    .full_por_o(por), .supply_monitor_disable_o(mdis), .core_power_source_select_o(psel),
    .rtc_clock_output_enable_o(rtc_clock_output_enable), .wake_request_n_o(wk_n), .wake_request_oe_o(wkoe));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      conclude();
    end
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data is registered, so sample one edge after the strobe is taken
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk); #1;
    cmp($sformatf("reg %h", a), exp, rdata);
  endtask
  // Event pulse on one source, then settle so the flag is visible
  task automatic ev(input int i);
    @(posedge clk); src[i] <= 1'b1;
    repeat (2) @(posedge clk);
    src[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h87, 8'h00);
    rd_reg(8'hb6, 8'h00);
    wr_reg(8'h87, 8'hff); #1;
    cmp("stop", 8'h01, {7'h0, stp});
    cmp("idle", 8'h01, {7'h0, idl});
    rd_reg(8'h87, 8'hfc);
    cmp("core_power_source_select", 8'h01, {7'h0, psel});
    wr_reg(8'hb6, 8'hff);
    rd_reg(8'hb6, 8'he0);
    cmp("outputs", 8'h07, {5'h0, rtc_clock_output_enable, wkoe, mdis});
    @(posedge clk); por_req <= 1'b1;
    @(posedge clk); por_req <= 1'b0;
    #1;
    cmp("full por", 8'h01, {7'h0, por});
    @(posedge clk); #1;
    cmp("monitor", 8'h00, {7'h0, mdis});
    $display("test registers done");
    // Each config register source sets its flag with no enable written
    for (n = 0; n < 5; n++) begin
      ev(n);
      rd_reg(8'hb5, 8'h01 << n);
      wr_reg(8'hb5, 8'h20);
    end
    ev(6); ev(5);
    rd_reg(8'hb6, 8'hc5);
    ev(0);
    wr_reg(8'hb5, 8'h40);
    repeat (2) @(posedge clk); #1;
    cmp("refused suspend", 8'h00, {7'h0, sus});
    wr_reg(8'hb5, 8'h20);
    rd_reg(8'hb6, 8'hc0);
    rd_reg(8'hb5, 8'h00);
    $display("test flags done");
    // Suspend with alarm enabled, woken by alarm
    wr_reg(8'hb5, 8'h44);
    @(posedge clk); #1;
    cmp("suspend", 8'h01, {7'h0, sus});
    cmp("clock gate", 8'h01, {7'h0, gate});
    cmp("oscillator", 8'h00, {7'h0, osc});
    // Alarm wakes; a read in the second cycle after must see blanked flags
    @(posedge clk); src[2] <= 1'b1;
    @(posedge clk); addr <= 8'hb5; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0; src[2] <= 1'b0;
    @(posedge clk); #1;
    cmp("blanked flags", 8'h00, rdata);
    for (n = 0; n < 20 && sus !== 1'b0; n++) begin
      @(posedge clk); #1;
    end
    cmp("suspend woke", 8'h00, {7'h0, sus});
    repeat (3) @(posedge clk);
    rd_reg(8'hb5, 8'h04);
    wr_reg(8'hb5, 8'h20);
    $display("test suspend done");
    // Sleep with port match enabled and wake request output on
    wr_reg(8'hb6, 8'h40);
    wr_reg(8'hb5, 8'h82);
    @(posedge clk); #1;
    cmp("sleep", 8'h01, {7'h0, slp});
    @(posedge clk); src[1] <= 1'b1;
    for (n = 0; n < 20 && wk_n !== 1'b0; n++) begin
      @(posedge clk); #1;
    end
    cmp("wake request", 8'h00, {7'h0, wk_n});
    src[1] <= 1'b0;
    repeat (3) @(posedge clk); #1;
    cmp("sleep left", 8'h00, {7'h0, slp});
    $display("test sleep done");
    conclude();
  end
endmodule
`default_nettype wire
